//--- event_action_sequencer.sv
// Purpose: Event/action sequencer stepping through programmed pairs
// Assumes: Classic Wishbone slave, synchronous reset, 200 MHz clock
// Notes: Pair word: [1:0] source, [4:2] select, [5] invert, [15:8] action code
`timescale 1ns/1ps
`include "sequencer_defs.svh"
// What this block does
// - Event n tied to action n
// - After action, test next event
// - Only one event tested at once
// - False event: nothing, retry next scan
// - On start, only event zero tested
// - Sequence length one to twenty pairs
// - After last pair, wrap to zero
// - Event source: status, rule or comparator
// - Comparators test values against presets
// - Logic rules combine three inputs
module event_action_sequencer import sequencer_pkg::*; #(
  parameter int SCAN_CYCLES = `SCAN_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [`N_STATUS-1:0] status_i,
  input wire logic [`N_ANA*`ANA_W-1:0] analog_i,
  output logic [`ACT_W-1:0] action_o,
  output logic action_valid_o,
  output logic [`IDX_W-1:0] index_o
);
  if (SCAN_CYCLES < 2) begin : g_bad_scan
    $error("SCAN_CYCLES too small");
  end

  localparam int TW = $clog2(SCAN_CYCLES + 1);

  function automatic logic sel_byte(input logic [3:0] sel, input logic [31:0] d,
                                    input logic [31:0] q, output logic [31:0] r);
    for (int b = 0; b < 4; b++) begin
      r[b*8 +: 8] = sel[b] ? d[b*8 +: 8] : q[b*8 +: 8];
    end
    return 1'b1;
  endfunction

  function automatic logic cmp_eval(input logic [1:0] op, input logic [`ANA_W-1:0] a,
                                    input logic [`ANA_W-1:0] p);
    case (op)
      CMP_GT: cmp_eval = a > p;
      CMP_LT: cmp_eval = a < p;
      CMP_EQ: cmp_eval = a == p;
      default: cmp_eval = a != p;
    endcase
  endfunction

  // Wishbone decode
  logic ack_ff;
  wire req = wb_cyc_i && wb_stb_i && !ack_ff;
  // Writes land at the edge where the master sees ack, not before
  wire wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;
  wire hit_ctrl = wb_adr_i == `ADR_CTRL;
  wire hit_stat = wb_adr_i == `ADR_STAT;
  wire hit_len = wb_adr_i == `ADR_LEN;
  wire hit_rule = wb_adr_i[7:4] == `ADR_RULE0 >> 4;
  wire hit_cmp = wb_adr_i[7:4] == `ADR_CMP0 >> 4;
  wire hit_pair = wb_adr_i[7:2] >= (`ADR_PAIR0 >> 2)
      && wb_adr_i[7:2] < 6'((`ADR_PAIR0 >> 2) + `PAIRS_MAX);
  wire [1:0] sub = wb_adr_i[3:2];
  wire [`IDX_W-1:0] pair_w = `IDX_W'(wb_adr_i[7:2] - 6'(`ADR_PAIR0 >> 2));

  logic run_ff;
  logic [`IDX_W-1:0] len_ff;
  logic [31:0] rule_ff [`N_RULE];
  logic [31:0] cmp_ff [`N_CMP];
  logic [31:0] ctrl_m, len_m, rule_m, cmp_m, pair_m;
  logic ok0, ok1, ok2, ok3;
  always_comb begin
    ok0 = sel_byte(wb_sel_i, wb_dat_i, {31'h0, run_ff}, ctrl_m);
    ok1 = sel_byte(wb_sel_i, wb_dat_i, {27'h0, len_ff}, len_m);
    ok2 = sel_byte(wb_sel_i, wb_dat_i, rule_ff[sub], rule_m);
    ok3 = sel_byte(wb_sel_i, wb_dat_i, cmp_ff[sub], cmp_m);
  end
  // Pair words are written whole; sub-word writes to memory are not merged
  assign pair_m = wb_dat_i;

  // Logic rules: word [3:0] inputs a, [7:4] b, [11:8] c, [14:12] invert, [17:16] op
  logic [`N_RULE-1:0] rule_out;
  logic [`N_CMP-1:0] cmp_out;
  logic [15:0] bool_pool;
  assign bool_pool = {cmp_out, status_i[`N_STATUS-1:0], rule_out};
  for (genvar r = 0; r < `N_RULE; r++) begin : g_rule
    wire ia = bool_pool[rule_ff[r][3:0]] ^ rule_ff[r][12];
    wire ib = bool_pool[rule_ff[r][7:4]] ^ rule_ff[r][13];
    wire ic = bool_pool[rule_ff[r][11:8]] ^ rule_ff[r][14];
    wire [1:0] op = rule_ff[r][17:16];
    // Rules feed later rules only through a register to avoid loops
    logic q_ff;
    wire nxt_q = (op == OP_AND) ? (ia & ib & ic) :
                 (op == OP_OR) ? (ia | ib | ic) : (op == OP_ALWAYS);
    always_ff @(posedge clk_i) begin
      q_ff <= rst_i ? 1'b0 : nxt_q;
    end
    assign rule_out[r] = q_ff;
  end

  // Comparators: word [15:0] preset, [17:16] op, [19:18] analog channel
  for (genvar c = 0; c < `N_CMP; c++) begin : g_cmp
    wire [1:0] ch = cmp_ff[c][19:18];
    wire [`ANA_W-1:0] val = analog_i[ch*`ANA_W +: `ANA_W];
    assign cmp_out[c] = cmp_eval(cmp_ff[c][17:16], val, cmp_ff[c][15:0]);
  end

  // Scan tick
  logic [TW-1:0] tick_cnt_ff;
  wire tick = tick_cnt_ff == TW'(SCAN_CYCLES - 1);
  always_ff @(posedge clk_i) begin
    if (rst_i || tick || !run_ff) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 1'b1;
    end
  end

  // Sequencer
  logic [`IDX_W-1:0] idx_ff;
  logic [31:0] pair_q;
  seq_state_e state_ff;
  pair_mem #(.DEPTH(`PAIRS_MAX), .WIDTH(32)) u_mem (
    .clk_i(clk_i),
    .we_i(wr && hit_pair),
    .waddr_i(pair_w),
    .wdata_i(pair_m),
    .raddr_i(idx_ff),
    .rdata_o(pair_q)
  );
  wire [1:0] src = pair_q[1:0];
  wire [2:0] psel = pair_q[4:2];
  logic ev_raw;
  always_comb begin
    case (src)
      SRC_STATUS: ev_raw = status_i[psel];
      SRC_RULE: ev_raw = rule_out[psel[1:0]];
      SRC_CMP: ev_raw = cmp_out[psel[1:0]];
      default: ev_raw = 1'b0;
    endcase
  end
  // Single event under test: only the pointed pair is ever decoded
  wire ev_true = ev_raw ^ pair_q[5];
  wire fire = run_ff && state_ff == ST_SCAN && tick && ev_true;
  wire last = idx_ff >= len_ff - 1'b1;
  wire [`IDX_W-1:0] nxt_idx = last ? '0 : idx_ff + 1'b1;

  seq_state_e nxt_state;
  always_comb begin
    case (state_ff)
      ST_IDLE: nxt_state = ST_SCAN;
      ST_SCAN: nxt_state = ST_SCAN;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_ff) begin
      state_ff <= ST_IDLE;
      idx_ff <= '0;
      action_valid_o <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      action_valid_o <= fire;
      if (fire) begin
        idx_ff <= nxt_idx;
      end
    end
  end

  // Last action code survives a stop so software can still read it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      action_o <= '0;
    end else if (fire) begin
      action_o <= pair_q[15:8];
    end
  end
  assign index_o = idx_ff;

  // Register writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_ff <= 1'b0;
      len_ff <= `LEN_RST;
      ack_ff <= 1'b0;
      for (int i = 0; i < `N_RULE; i++) begin
        rule_ff[i] <= '0;
      end
      for (int i = 0; i < `N_CMP; i++) begin
        cmp_ff[i] <= '0;
      end
    end else begin
      ack_ff <= req;
      if (wr && hit_ctrl) begin
        run_ff <= ctrl_m[`CTRL_RUN];
      end
      // Lengths whose low five bits fall outside 1 to 20 are ignored so the pointer stays valid
      if (wr && hit_len && len_m[`IDX_W-1:0] >= 1
          && len_m[`IDX_W-1:0] <= `IDX_W'(`PAIRS_MAX)) begin
        len_ff <= len_m[`IDX_W-1:0];
      end
      if (wr && hit_rule) begin
        rule_ff[sub] <= rule_m;
      end
      if (wr && hit_cmp) begin
        cmp_ff[sub] <= cmp_m;
      end
    end
  end
  assign wb_ack_o = ack_ff;

  // Read data registered; pair words are write-only
  logic [31:0] rd_ff;
  logic [31:0] nxt_rd;
  always_comb begin
    nxt_rd = 32'h0;
    if (hit_ctrl) nxt_rd = {31'h0, run_ff};
    else if (hit_stat) nxt_rd = {16'h0, action_o, 2'h0, state_ff == ST_SCAN, idx_ff};
    else if (hit_len) nxt_rd = {27'h0, len_ff};
    else if (hit_rule) nxt_rd = rule_ff[sub];
    else if (hit_cmp) nxt_rd = cmp_ff[sub];
  end
  always_ff @(posedge clk_i) begin
    rd_ff <= rst_i ? 32'h0 : (req ? nxt_rd : rd_ff);
  end
  assign wb_dat_o = rd_ff;

  wire unused = ok0 & ok1 & ok2 & ok3 & (|pair_q[31:16]) & pair_q[7] & pair_q[6];
endmodule

//--- sequencer_defs.svh
// Purpose: Constants for the event/action sequencer
// Assumes: 200 MHz system clock
// Notes: Register offsets are byte addresses on a 32-bit Wishbone bus
`ifndef SEQUENCER_DEFS_SVH
`define SEQUENCER_DEFS_SVH

`define PAIRS_MAX 20
`define IDX_W 5
`define N_STATUS 8
`define N_CMP 4
`define N_RULE 4
`define N_ANA 4
`define ANA_W 16
`define ACT_W 8
`define SCAN_NS 1000000
`define CLK_NS 5
`define SCAN_CYC (`SCAN_NS / `CLK_NS)

`define ADR_CTRL 8'h00
`define ADR_STAT 8'h04
`define ADR_LEN 8'h08
`define ADR_RULE0 8'h10
`define ADR_CMP0 8'h20
`define ADR_PAIR0 8'h40

`define CTRL_RUN 0
`define LEN_RST 5'h01
`define ANA_IN 3'h2

`endif

//--- sequencer_pkg.sv
// Purpose: Types for the event/action sequencer
// Assumes: Included constants header
// Notes: Types only
package sequencer_pkg;
  typedef enum logic [1:0] {
    SRC_STATUS = 2'h0,
    SRC_RULE = 2'h1,
    SRC_CMP = 2'h2,
    SRC_NEVER = 2'h3
  } src_e;
  typedef enum logic [1:0] {
    OP_AND = 2'h0,
    OP_OR = 2'h1,
    OP_XOR_UNUSED = 2'h2,
    OP_ALWAYS = 2'h3
  } rule_op_e;
  typedef enum logic [1:0] {
    CMP_GT = 2'h0,
    CMP_LT = 2'h1,
    CMP_EQ = 2'h2,
    CMP_NE = 2'h3
  } cmp_op_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SCAN = 2'h1
  } seq_state_e;
endpackage

//--- pair_mem.sv
// Purpose: Storage of programmed event/action pairs
// Assumes: One write port, one registered read port
// Notes: Read data appears one cycle after the address
`timescale 1ns/1ps
`include "sequencer_defs.svh"
module pair_mem #(
  parameter int DEPTH = `PAIRS_MAX,
  parameter int WIDTH = 32
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [`IDX_W-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [`IDX_W-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] rdata_ff;

  // Refused at elaboration, since the write address cannot reach more words
  if (DEPTH < 1 || DEPTH > (1 << `IDX_W)) begin : g_bad_depth
    $error("pair_mem depth out of range");
  end

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_ff[waddr_i] <= wdata_i;
    end
    rdata_ff <= mem_ff[raddr_i];
  end

  assign rdata_o = rdata_ff;
endmodule

//--- seq_checker.sv
// Purpose: Port checks for the sequencer
// Assumes: Sees only the top module ports
// Notes: Bound from the bench top file
`timescale 1ns/1ps
module seq_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [7:0] action_o,
  input wire logic action_valid_o,
  input wire logic [4:0] index_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  one_event_a: assert property (action_valid_o |=> !action_valid_o [*3])
    else $error("actions too close");
  tick_advance_a: assert property ($changed(index_o) && index_o != 5'h00 |->
    action_valid_o || $past(action_valid_o) or ##1 action_valid_o)
    else $error("pointer moved without action");
  len_range_a: assert property (index_o <= 5'h13)
    else $error("pointer out of range");
  wrap_step_a: assert property ($changed(index_o) |->
    index_o == $past(index_o) + 5'h01 || index_o == 5'h00)
    else $error("pointer skipped a pair");
  pair_action_a: assert property ($changed(action_o) |-> action_valid_o)
    else $error("action changed without execution");
  // Own disable, since reset itself is the cause here
  reset_clear_a: assert property (disable iff (1'b0) rst_i |=>
    index_o == 5'h00 && !action_valid_o && !wb_ack_o)
    else $error("reset did not clear");
  cover property (action_valid_o && index_o == 5'h00);
  cover property (wb_ack_o);
  cover property ($changed(index_o));
endmodule

//--- test_event_action_sequencer.sv
// Purpose: Self-checking bench for the sequencer
// Assumes: Scan period shortened to 8 clocks
// Notes: Classic Wishbone master tasks
`timescale 1ns/1ps
`include "sequencer_defs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t: got %0h exp %0h", $time, g, e); end end
bind event_action_sequencer seq_checker chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .action_o(action_o),
  .action_valid_o(action_valid_o), .index_o(index_o));
module test_event_action_sequencer;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00, st = 8'h00;
  logic [31:0] dat = 32'h0, q;
  logic [63:0] ana = 64'h0;
  logic [31:0] rd;
  logic ack, vld;
  logic [7:0] act;
  logic [4:0] idx;
  int failures = 0, comparisons = 0, ticks = 0, i;
  logic [15:0] av [4] = '{16'h0101, 16'h00ff, 16'h0100, 16'h00ff};
  always #2.5 clk_i = ~clk_i;
  event_action_sequencer #(.SCAN_CYCLES(8)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_sel_i(4'hf), .wb_dat_o(rd), .wb_ack_o(ack), .status_i(st), .analog_i(ana),
    .action_o(act), .action_valid_o(vld), .index_o(idx));
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask
  // Bounded wait, so a missing action shows as a mismatch
  task automatic step(input logic [7:0] e, input logic [4:0] n);
    int k;
    k = 0;
    while (vld !== 1'b1 && k < 100) begin
      @(posedge clk_i);
      k++;
    end
    `CHK(vld, 1'b1)
    `CHK(act, e)
    @(posedge clk_i);
    `CHK(idx, n)
  endtask
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge clk_i);
      `CHK(vld, 1'b0)
    end
  endtask
  task automatic tally_and_finish;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_i) begin
    ticks++;
    if (ticks == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(`ADR_CTRL, 32'h0);
    rdchk(`ADR_LEN, 32'h1);
    rdchk(8'hfc, 32'h0);
    bus(1'b1, `ADR_RULE0, 32'h4876);
    bus(1'b1, `ADR_CMP0, 32'h00080100);
    bus(1'b1, 8'h40, 32'h1100);
    bus(1'b1, 8'h44, 32'h2224);
    bus(1'b1, 8'h48, 32'h3302);
    bus(1'b1, 8'h4c, 32'h4401);
    rdchk(8'h44, 32'h0);
    bus(1'b1, `ADR_LEN, 32'h4);
    bus(1'b1, `ADR_LEN, 32'h15);
    bus(1'b1, `ADR_LEN, 32'h0);
    rdchk(`ADR_LEN, 32'h4);
    bus(1'b1, `ADR_CTRL, 32'h1);
    // Pair one is already true here, yet must not fire
    quiet(40);
    st <= 8'h01;
    step(8'h11, 5'h01);
    step(8'h22, 5'h02);
    quiet(30);
    ana[47:32] <= 16'h0101;
    step(8'h33, 5'h03);
    st <= 8'h0d;
    step(8'h44, 5'h00);
    step(8'h11, 5'h01);
    bus(1'b1, `ADR_CTRL, 32'h0);
    st <= 8'h00;
    rdchk(`ADR_STAT, 32'h1100);
    bus(1'b1, `ADR_CTRL, 32'h1);
    quiet(24);
    `CHK(idx, 5'h00)
    bus(1'b1, `ADR_LEN, 32'h1);
    bus(1'b1, 8'h40, 32'h5502);
    for (i = 0; i < 4; i++) begin
      bus(1'b1, `ADR_CTRL, 32'h0);
      bus(1'b1, `ADR_CMP0, {12'h000, 2'h2, 2'(i), 16'h0100});
      // Neighbour value lies on the false side of the preset for this op
      ana[47:32] <= av[i ^ 1];
      bus(1'b1, `ADR_CTRL, 32'h1);
      quiet(24);
      ana[47:32] <= av[i];
      step(8'h55, 5'h00);
    end
    tally_and_finish();
  end
endmodule
